// >>> src/diag_mux_interconnect_ctrl.sv
`timescale 1ns/1ps
`include "diag_consts.svh"
`default_nettype none
module diag_mux_interconnect_ctrl
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic              self_test_reinit,
  // register commands
  input  wire diag_pkg::reg_cmd_s cmd,
  output logic [7:0]             rdata,
  output logic                   rvalid,
  // observed pins
  input  wire diag_pkg::pin_in_s pins,
  // internal signal sources
  input  wire logic [255:0]      digital_sources,
  output logic [7:0]             analog_channel,
  output logic                   analog_enable,
  // diagnostic mux pin
  output logic                   mux_pin_out,
  output logic                   mux_pin_oe,
  // serial data out test override
  output logic                   sdo_test_active,
  output logic                   sdo_test_level
);
  import diag_pkg::*;

  logic [7:0] diag_config_control_q;
  logic [7:0] diag_channel_register_q;
  logic [7:0] rdata_q;
  logic       rvalid_q;
  logic       mux_static_level_q;
  logic       mux_oe_q;
  logic       sdo_act_q;
  logic       sdo_lvl_q;
  logic [7:0] ana_ch_q;
  logic       ana_en_q;
  logic       mux_d;
  pin_in_s    pins_s;

  logic       mux_output_enable;
  logic       serial_out_test_level;
  logic       mux_static_level;
  logic [2:0] interconnect_input_select;
  logic [1:0] mux_mode_select;
  logic [7:0] mux_channel_select;

  // pins come from outside, two flops first
  diag_sync diag_sync_inst
  (
    .mclk     (mclk),
    .rstn     (rstn),
    .pins_in  (pins),
    .pins_out (pins_s)
  );

  assign mux_output_enable         = diag_config_control_q[`BIT_OUT_EN];
  assign serial_out_test_level     = diag_config_control_q[`BIT_SDO_LEVEL];
  assign mux_static_level          = diag_config_control_q[`BIT_STATIC_LEVEL];
  assign interconnect_input_select = diag_config_control_q[`FLD_IC_HI:`FLD_IC_LO];
  assign mux_mode_select           = diag_config_control_q[`FLD_MODE_HI:`FLD_MODE_LO];
  assign mux_channel_select        = diag_channel_register_q;

  // mode compare shared by pin, analog and data out paths
  function automatic logic mode_is(input logic [1:0] mode, input logic [1:0] code);
  begin
    mode_is = (mode == code);
  end
  endfunction

  // interconnect test: one input pin at a time, unused codes read low
  function automatic logic pick_pin(input pin_in_s p, input logic [2:0] sel);
  begin
    case (sel)
      `IC_ERR:  pick_pin = p.err;
      `IC_CS:   pick_pin = p.cs;
      `IC_SDI:  pick_pin = p.sdi;
      `IC_SCLK: pick_pin = p.sclk;
      default:  pick_pin = 1'b0;
    endcase
  end
  endfunction

  // channel data wins when both reads land in one cycle
  function automatic logic [7:0] read_value(input reg_cmd_s c, input logic [7:0] ctrl, input logic [7:0] chan);
  begin
    if (c.read_channel_command)
      read_value = chan;
    else if (c.read_ctrl)
      read_value = ctrl;
    else
      read_value = `RDATA_IDLE;
  end
  endfunction

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      diag_config_control_q <= `CTRL_RESET;
    // reinit beats a write on the same edge
    else if (self_test_reinit)
      diag_config_control_q <= `CTRL_RESET;
    else if (cmd.write_ctrl)
      diag_config_control_q <= cmd.wdata;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      diag_channel_register_q <= `SEL_RESET;
    // reinit first, a write in that cycle is lost
    else if (self_test_reinit)
      diag_channel_register_q <= `SEL_RESET;
    else if (cmd.write_channel_command)
      diag_channel_register_q <= cmd.wdata;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rvalid_q <= 1'b0;
    else
      rvalid_q <= cmd.read_ctrl | cmd.read_channel_command;
  end

  // data stays zero between answers
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= `RDATA_IDLE;
    else
      rdata_q <= read_value(cmd, diag_config_control_q, mux_channel_select);
  end

  always_comb
  begin
    mux_d = 1'b0;
    case (mux_mode_select)
      `MODE_STATIC:   mux_d = mux_static_level;
      // 256 sources, so every selector code lands on one
      // selector indexes digital set
      `MODE_DIGITAL:  mux_d = digital_sources[mux_channel_select];
      // analog level never enters this digital path
      `MODE_ANALOG:   mux_d = 1'b0;
      `MODE_INTERCON: mux_d = pick_pin(pins_s, interconnect_input_select);
      default:        mux_d = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      mux_static_level_q <= 1'b0;
    else
      mux_static_level_q <= mux_output_enable & mux_d;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      mux_oe_q <= 1'b0;
    else
      mux_oe_q <= mux_output_enable & !mode_is(mux_mode_select, `MODE_ANALOG);
  end

  // analog path takes selector as channel
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      ana_ch_q <= `SEL_RESET;
    else
      ana_ch_q <= mux_channel_select;
  end

  // analog level leaves by its own path, so the pin stays released
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      ana_en_q <= 1'b0;
    else
      ana_en_q <= mux_output_enable & mode_is(mux_mode_select, `MODE_ANALOG);
  end

  // synchronised cs plus this flop, so active follows the pin three cycles late
  // data out test, chip-select high
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      sdo_act_q <= 1'b0;
    else
      sdo_act_q <= mode_is(mux_mode_select, `MODE_DIGITAL) & pins_s.cs;
  end

  // level passes in any mode, only active gates the buffer
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      sdo_lvl_q <= 1'b0;
    else
      sdo_lvl_q <= serial_out_test_level;
  end

  // outputs straight from their flops
  assign rdata           = rdata_q;
  assign rvalid          = rvalid_q;
  assign mux_pin_out     = mux_static_level_q;
  assign mux_pin_oe      = mux_oe_q;
  assign analog_channel  = ana_ch_q;
  assign analog_enable   = ana_en_q;
  assign sdo_test_active = sdo_act_q;
  assign sdo_test_level  = sdo_lvl_q;
endmodule
`default_nettype wire

// >>> src/diag_consts.svh
`ifndef DIAG_CONSTS_SVH
`define DIAG_CONSTS_SVH
`define CTRL_RESET       8'h00
`define SEL_RESET        8'h00
`define RDATA_IDLE       8'h00
`define BIT_OUT_EN       7
`define BIT_SDO_LEVEL    6
`define BIT_STATIC_LEVEL 5
`define FLD_IC_HI        4
`define FLD_IC_LO        2
`define FLD_MODE_HI      1
`define FLD_MODE_LO      0
`define IC_NONE          3'h0
`define IC_ERR           3'h1
`define IC_CS            3'h2
`define IC_SDI           3'h3
`define IC_SCLK          3'h4
`define MODE_STATIC      2'h0
`define MODE_DIGITAL     2'h1
`define MODE_ANALOG      2'h2
`define MODE_INTERCON    2'h3
`endif

// >>> src/diag_pkg.sv
package diag_pkg;
  typedef enum logic [1:0] {cmd_none, cmd_read_ctrl, cmd_write_ctrl, cmd_read_sel} cmd_base_e;
  typedef struct packed {
    logic       read_ctrl;
    logic       write_ctrl;
    logic       read_channel_command;
    logic       write_channel_command;
    logic [7:0] wdata;
  } reg_cmd_s;
  typedef struct packed {
    logic err;
    logic cs;
    logic sdi;
    logic sclk;
  } pin_in_s;
endpackage

// >>> src/diag_sync.sv
`timescale 1ns/1ps
`default_nettype none
module diag_sync
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // raw and synchronised pins
  input  wire diag_pkg::pin_in_s pins_in,
  output diag_pkg::pin_in_s      pins_out
);
  import diag_pkg::*;

  pin_in_s meta_q;
  pin_in_s sync_q;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= pins_in;
      sync_q <= meta_q;
    end
  end

  assign pins_out = sync_q;
endmodule
`default_nettype wire

// >>> test/pin_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_master_model
(
  // clock
  input  wire logic         mclk,
  // wanted levels and driven pins
  input  wire logic [3:0]   want,
  output diag_pkg::pin_in_s pins
);
  always_ff @(posedge mclk) pins <= want;
endmodule
`default_nettype wire

// >>> test/diag_mux_interconnect_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module diag_mux_interconnect_ctrl_properties
(
  // clock and reset
  input wire logic               mclk,
  input wire logic               rstn,
  input wire logic               self_test_reinit,
  // commands and outputs
  input wire diag_pkg::reg_cmd_s cmd,
  input wire logic [7:0]         rdata,
  input wire logic               rvalid,
  input wire logic               analog_enable,
  input wire logic               mux_pin_oe,
  input wire logic               mux_pin_out,
  input wire logic               sdo_test_level
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic wc;
  // reinit wins over a write, so it is left out
  assign wc = cmd.write_ctrl && !self_test_reinit;
  AST_OFF: assert property (wc && !cmd.wdata[7] |-> ##2 !mux_pin_oe && !mux_pin_out)
    else $error("pin on");
  AST_ON: assert property (wc && cmd.wdata[7] && cmd.wdata[1:0] != 2'h2 |-> ##2 mux_pin_oe)
    else $error("pin off");
  AST_RV: assert property (cmd.read_ctrl || cmd.read_channel_command |=> rvalid) else $error("no answer");
  AST_RV0: assert property (!cmd.read_ctrl && !cmd.read_channel_command |=> !rvalid && rdata == 8'h00)
    else $error("stray answer");
  AST_SEL: assert property (cmd.write_channel_command && !self_test_reinit ##1 cmd.read_channel_command |=>
    rdata == $past(cmd.wdata, 2)) else $error("bad readback");
  AST_CLR: assert property (self_test_reinit ##1 cmd.read_channel_command && !cmd.write_channel_command |=>
    rdata == 8'h00) else $error("not cleared");
  AST_ANA: assert property (wc && cmd.wdata == 8'h82 |-> ##2 analog_enable && !mux_pin_oe)
    else $error("analog");
  AST_SDO: assert property (wc |-> ##2 sdo_test_level == $past(cmd.wdata[6], 2))
    else $error("sdo level");
  AST_STAT: assert property (wc && cmd.wdata[7] && cmd.wdata[1:0] == 2'h0 |-> ##2
    mux_pin_out == $past(cmd.wdata[5], 2)) else $error("static level");
endmodule
`default_nettype wire

// >>> test/diag_mux_interconnect_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module diag_mux_interconnect_ctrl_bench;
  import diag_pkg::*;
  logic mclk = 0, rstn = 0, str = 0, rvalid, aen, mo, moe, sta, stl;
  reg_cmd_s cmd = '0;
  pin_in_s pins;
  logic [3:0] want = 4'h0;
  logic [255:0] ds = '0;
  logic [7:0] rdata, ach, c, s, p, lf = 8'h3f;
  int mismatches = 0, n_checks = 0;
  always #5 mclk = ~mclk;
  pin_master_model pin_master_model_inst (.mclk(mclk), .want(want), .pins(pins));
  diag_mux_interconnect_ctrl diag_mux_interconnect_ctrl_inst (.mclk(mclk), .rstn(rstn),
    .self_test_reinit(str), .cmd(cmd), .rdata(rdata), .rvalid(rvalid), .pins(pins), .digital_sources(ds),
    .analog_channel(ach), .analog_enable(aen), .mux_pin_out(mo), .mux_pin_oe(moe), .sdo_test_active(sta),
    .sdo_test_level(stl));
  function logic [7:0] nx();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  // {oe, out, analog, sdo active, sdo level}
  function logic [4:0] ex(logic [7:0] k, logic [7:0] q, logic [3:0] pn);
    logic b;
    case (k[1:0])
      2'h0: b = k[5];
      2'h1: b = ds[q];
      2'h2: b = 1'b0;
      default: b = (k[4:2] > 3'h0 && k[4:2] < 3'h5) ? pn[3'h4 - k[4:2]] : 1'b0;
    endcase
    return {k[7] && k[1:0] != 2'h2, k[7] && b, k[7] && k[1:0] == 2'h2, k[1:0] == 2'h1 && pn[2], k[6]};
  endfunction
  task chk(logic [8:0] g, logic [8:0] e);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task go(logic [3:0] k, logic [7:0] d);
    @(posedge mclk);
    cmd <= {k, d};
  endtask
  task rd(logic [3:0] k, logic [7:0] e);
    go(k, 8'h00);
    go(4'h0, 8'h00);
    #1 chk({rvalid, rdata}, {1'b1, e});
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    rstn <= 1;
    rd(4'h8, 8'h00);
    rd(4'h2, 8'h00);
    go(4'h5, 8'h3c);
    rd(4'ha, 8'h3c);
    $display("done regs");
    for (int i = 0; i < 40; i++)
    begin
      c = i == 0 ? 8'ha0 : i == 1 ? 8'h82 : i == 2 ? 8'h8b : nx();
      s = nx();
      p = nx();
      go(4'h1, s);
      // pins and sources change on the edge of the selector write
      want <= p[3:0];
      ds <= {ds[247:0], s};
      go(4'h4, c);
      go(4'h0, 8'h00);
      // pins need sync time
      repeat (5) @(posedge mclk);
      #1 chk({ach, 1'b0}, {s, 1'b0});
      chk({4'h0, moe, mo, aen, sta, stl}, {4'h0, ex(c, s, p[3:0])});
      rd(4'h8, c);
      rd(4'h2, s);
    end
    $display("done mux");
    go(4'h5, 8'hff);
    str <= 1;
    go(4'h2, 8'h00);
    str <= 0;
    go(4'h0, 8'h00);
    #1 chk({rvalid, rdata}, 9'h100);
    rd(4'h8, 8'h00);
    $display("done reinit");
    // power-on reset again in mid-run, registers loaded first
    go(4'h5, 8'h9d);
    rd(4'h2, 8'h9d);
    @(posedge mclk);
    rstn <= 0;
    repeat (2) @(posedge mclk);
    rstn <= 1;
    #1 chk({4'h0, moe, mo, aen, sta, stl}, 9'h000);
    rd(4'ha, 8'h00);
    rd(4'h8, 8'h00);
    $display("done reset");
    finish_test;
  end
  initial
  begin
    #200000;
    mismatches++;
    finish_test;
  end
endmodule
bind diag_mux_interconnect_ctrl diag_mux_interconnect_ctrl_properties prop_inst (.mclk(mclk), .rstn(rstn),
  .self_test_reinit(self_test_reinit), .cmd(cmd), .rdata(rdata), .rvalid(rvalid), .analog_enable(analog_enable),
  .mux_pin_oe(mux_pin_oe), .mux_pin_out(mux_pin_out), .sdo_test_level(sdo_test_level));
`default_nettype wire
